// File: hdl/fhi_pkg.sv
// Purpose: shared constants and carriers for the floppy host instruction port
// Assumes: 12-bit host words, 8-bit controller-side register bus
// Notes:   error codes are octal values written as hex
package fhi_pkg;

	// ****************************************
	// widths and register map
	// ****************************************
	localparam int          WORD_W      = 12;
	localparam int          RADDR_W     = 3;
	localparam logic [2:0]  REG_CMD     = 3'h0;
	localparam logic [2:0]  REG_DATA    = 3'h1;
	localparam logic [2:0]  REG_FLAGS   = 3'h2;
	localparam logic [2:0]  REG_ERR     = 3'h3;
	localparam logic [2:0]  REG_STAT    = 3'h4;
	localparam logic [2:0]  REG_CFG     = 3'h5;
	localparam logic [2:0]  REG_COUNT   = 3'h6;

	// ****************************************
	// instruction word fields
	// ****************************************
	localparam logic [2:0]  IOT_GROUP   = 3'h6;
	localparam logic [2:0]  OP_NOP      = 3'h0;
	localparam logic [2:0]  OP_LOAD     = 3'h1;
	localparam logic [2:0]  OP_XFER     = 3'h2;
	localparam logic [2:0]  OP_SKTR     = 3'h3;
	localparam logic [2:0]  OP_SKER     = 3'h4;
	localparam logic [2:0]  OP_SKDN     = 3'h5;
	localparam logic [2:0]  OP_IEN      = 3'h6;
	localparam logic [2:0]  OP_INIT     = 3'h7;

	// ****************************************
	// command word fields and function codes
	// ****************************************
	localparam int          CMD_WL_BIT  = 5;
	localparam int          CMD_DEN_BIT = 6;
	localparam int          CMD_DRV_BIT = 7;
	localparam int          CMD_FN_LSB  = 8;
	localparam int          ACC_IE_BIT  = 0;
	localparam logic [2:0]  FN_FILL     = 3'h0;
	localparam logic [2:0]  FN_EMPTY    = 3'h1;
	localparam logic [2:0]  FN_WRITE    = 3'h2;
	localparam logic [2:0]  FN_READ     = 3'h3;
	localparam logic [2:0]  FN_DENSITY  = 3'h4;
	localparam logic [2:0]  FN_RSTAT    = 3'h5;
	localparam logic [2:0]  FN_WDEL     = 3'h6;
	localparam logic [2:0]  FN_RERR     = 3'h7;
	localparam logic [11:0] BYTE_MASK   = 12'h0ff;

	// ****************************************
	// sector sizing, status bits, vector
	// ****************************************
	localparam logic [8:0]  SEC_BYTES   = 9'h080;
	localparam logic [8:0]  SEC_WORDS12 = 9'h040;
	localparam int          ST_CRC_BIT  = 0;
	localparam int          ST_PAR_BIT  = 1;
	localparam int          ST_INIT_BIT = 2;
	localparam logic [8:0]  IRQ_VECTOR  = 9'h0b4;
	localparam logic [11:0] TRACK_MAX   = 12'h04c;
	localparam logic [2:0]  DEVCODE_RST = 3'h0;

	// ****************************************
	// definitive error codes
	// ****************************************
	localparam logic [7:0]  ERR_NONE    = 8'h00;
	localparam logic [7:0]  ERR_DRV0    = 8'h08;
	localparam logic [7:0]  ERR_DRV1    = 8'h10;
	localparam logic [7:0]  ERR_STEPIN  = 8'h18;
	localparam logic [7:0]  ERR_TRACK   = 8'h20;
	localparam logic [7:0]  ERR_TRK0    = 8'h28;
	localparam logic [7:0]  ERR_NOSEC   = 8'h38;
	localparam logic [7:0]  ERR_WPROT   = 8'h40;
	localparam logic [7:0]  ERR_NORD    = 8'h48;
	localparam logic [7:0]  ERR_NOPRE   = 8'h50;
	localparam logic [7:0]  ERR_NOAM    = 8'h58;
	localparam logic [7:0]  ERR_HCRC    = 8'h60;
	localparam logic [7:0]  ERR_TRKMIS  = 8'h68;
	localparam logic [7:0]  ERR_IDTRY   = 8'h70;
	localparam logic [7:0]  ERR_DAMTO   = 8'h78;
	localparam logic [7:0]  ERR_DCRC    = 8'h80;
	localparam logic [7:0]  ERR_PARITY  = 8'h88;
	localparam logic [7:0]  ERR_WCOUNT  = 8'h98;
	localparam logic [7:0]  ERR_DENS    = 8'ha0;
	localparam logic [7:0]  ERR_KEY     = 8'ha8;
	localparam logic [7:0]  ERR_NOMEDIA = 8'hb0;
	localparam logic [7:0]  ERR_NXM     = 8'he8;
	localparam logic [7:0]  ERR_NOTRDY  = 8'hf0;
	localparam logic [7:0]  ERR_ACLOW   = 8'hf8;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic        valid;
		logic [11:0] instr;
		logic [11:0] acc;
	} fhi_iot_s;

	typedef struct packed {
		logic        skip;
		logic        acc_clear;
		logic        acc_jam;
		logic        acc_or;
		logic [11:0] acc_data;
	} fhi_ans_s;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_CMD_HI = 3'b010,
		ST_RUN    = 3'b100
	} fhi_state_e;

endpackage : fhi_pkg

// File: hdl/fhi_host_port.sv
// Purpose: host instruction decode, interface register and flags for a floppy controller
// Assumes: instruction strobe and accumulator on the same clock; controller side via reg port
// Notes:   the controller firmware drives flags, data offers and error codes through registers
//
// Overview of operation
// - read status completion may take two revolutions; done comes only from the controller
// - status word carries an init-done bit 2 revealing power loss
// - drive select ignored for fill and empty buffer functions
// - interrupt request while interrupt enable and done are both set; vector 264
// - sector holds 128 bytes or 64 twelve-bit words, rest zero padded
// - double density keeps both word lengths and doubles words per sector
// - error code zero when clean; 040 track over 76; 050 early track zero
// - code 070 sector not found, 100 write protect violation
// - code 200 also sets status bit 0, code 210 sets status bit 1
// - init faults coded 010, 020 and 030
// - codes 230, 240, 250 and 260 for count, density, key, media
// - header search failures coded 110 through 170
// - codes 350 memory, 360 drive not ready, 370 low power
// - low octal digit selects one of eight operations, middle digit ignored
// - load command copies accumulator into interface register, clears accumulator
// - extended 8-bit mode sends upper four command bits by transfer after request
// - transfer direction from active function, width from last word length setting
// - transfer while not done acknowledges the word offered or requested
// - host-to-device transfer leaves accumulator; after done, delivers status word
// - 12-bit transfers overwrite accumulator, 8-bit transfers are ORed in
// - skip on transfer request skips when set and clears the flag
// - setting error also sets done; done may set alone
// - interrupt enable follows accumulator bit 0; cleared by any initialize
// - command bits 8 to 10 select the function
// - command bit 5 picks 8-bit words; then only bits 0 to 7 matter
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps

module fhi_host_port
	import fhi_pkg::*;
(
	// clock and reset
	input  wire logic               clock,
	input  wire logic               rst,
	// host instruction bus
	input  wire fhi_iot_s           iot,
	input  wire logic               bus_init,
	output fhi_ans_s                ans,
	output logic                    irq,
	output logic [8:0]              irq_vector,
	// controller register port
	input  wire logic [RADDR_W-1:0] reg_addr,
	input  wire logic [7:0]         reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic [7:0]              reg_rdata,
	output logic                    init_req
);

	// ****************************************
	// state
	// ****************************************
	fhi_state_e  state_q,  state_d;
	logic [11:0] iface_q;
	logic [11:0] cmd_q;
	logic [11:0] status_q;
	logic [7:0]  err_q;
	logic        treq_q, err_flag_q, done_q, ie_q;
	logic        offer_q, ack_q, cmd_new_q;
	logic        ext_mode_q;
	logic [2:0]  devcode_q;
	logic [8:0]  count_q;

	// ****************************************
	// instruction decode
	// ****************************************
	wire         sel      = iot.valid && iot.instr[11:9] == IOT_GROUP
	                        && iot.instr[8:6] == devcode_q;
	wire [2:0]   op       = iot.instr[2:0];
	wire         do_load  = sel && op == OP_LOAD;
	wire         do_xfer  = sel && op == OP_XFER;
	wire         do_sktr  = sel && op == OP_SKTR;
	wire         do_sker  = sel && op == OP_SKER;
	wire         do_skdn  = sel && op == OP_SKDN;
	wire         do_ien   = sel && op == OP_IEN;
	wire         do_init  = (sel && op == OP_INIT) || bus_init;

	wire [2:0]   fn       = cmd_q[CMD_FN_LSB+2:CMD_FN_LSB];
	wire         byte_md  = cmd_q[CMD_WL_BIT];
	wire         dbl_den  = cmd_q[CMD_DEN_BIT];
	wire         no_drive = fn == FN_FILL || fn == FN_EMPTY;
	wire         drive    = no_drive ? 1'b0 : cmd_q[CMD_DRV_BIT];
	wire         to_host  = offer_q || fn == FN_EMPTY || fn == FN_RERR;
	wire [11:0]  xmask    = byte_md ? BYTE_MASK : 12'hfff;
	wire [8:0]   sec_base = byte_md ? SEC_BYTES : SEC_WORDS12;
	wire [8:0]   sec_cap  = dbl_den ? {sec_base[7:0], 1'b0} : sec_base;
	wire [8:0]   pad_cnt  = sec_cap - count_q;
	wire         trk_bad  = iface_q > TRACK_MAX;
	wire         cmd_hi   = state_q == ST_CMD_HI && do_xfer;
	wire         host_wr  = do_xfer && !done_q && !to_host;

	// ****************************************
	// controller register decode
	// ****************************************
	wire         wr_data  = reg_wr && reg_addr == REG_DATA;
	wire         wr_flags = reg_wr && reg_addr == REG_FLAGS;
	wire         wr_err   = reg_wr && reg_addr == REG_ERR;
	wire         wr_stat  = reg_wr && reg_addr == REG_STAT;
	wire         wr_cfg   = reg_wr && reg_addr == REG_CFG;
	wire         set_treq = wr_flags && reg_wdata[0];
	wire         set_err  = (wr_flags && reg_wdata[2]) || (wr_err && reg_wdata != ERR_NONE);
	wire         set_done = (wr_flags && reg_wdata[1]) || set_err;
	wire         clr_ack  = wr_flags && reg_wdata[3];

	// ****************************************
	// host answer
	// ****************************************
	fhi_ans_s    ans_d;
	always_comb
	begin
		ans_d = '0;
		if (do_load)
			ans_d.acc_clear = 1'b1;
		if (do_sktr)
			ans_d.skip = treq_q;
		if (do_sker)
			ans_d.skip = err_flag_q;
		if (do_skdn)
			ans_d.skip = done_q;
		if (do_xfer && (done_q || to_host))
		begin
			ans_d.acc_data = (done_q ? status_q : iface_q) & xmask;
			ans_d.acc_jam  = !byte_md;
			ans_d.acc_or   = byte_md;
		end
	end

	// ****************************************
	// state machine
	// ****************************************
	always_comb
	begin
		case (state_q)
			ST_IDLE:   state_d = do_load ? (ext_mode_q && iot.acc[CMD_WL_BIT] ? ST_CMD_HI : ST_RUN)
			                             : ST_IDLE;
			ST_CMD_HI: state_d = cmd_hi ? ST_RUN : ST_CMD_HI;
			ST_RUN:    state_d = set_done ? ST_IDLE : ST_RUN;
			default:   state_d = ST_IDLE;
		endcase
		if (do_init)
			state_d = ST_IDLE;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// ****************************************
	// interface register and command
	// ****************************************
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			iface_q <= '0;
			cmd_q   <= '0;
		end
		else if (do_load)
		begin
			iface_q <= iot.acc;
			cmd_q   <= iot.acc;
		end
		else if (cmd_hi)
			cmd_q[11:8] <= iot.acc[7:4];
		else if (host_wr)
			iface_q <= iot.acc & xmask;
		else if (wr_data)
			iface_q <= {4'h0, reg_wdata};
	end

	// ****************************************
	// flags
	// ****************************************
	always_ff @(posedge clock)
	begin
		if (rst || do_init)
		begin
			treq_q     <= 1'b0;
			err_flag_q <= 1'b0;
			done_q     <= 1'b0;
			ie_q       <= 1'b0;
		end
		else
		begin
			treq_q     <= set_treq || (wr_data || (do_load && ext_mode_q)) || (treq_q && !do_sktr);
			err_flag_q <= set_err || (err_flag_q && !do_sker);
			done_q     <= set_done || (done_q && !do_skdn);
			if (do_ien)
				ie_q <= iot.acc[ACC_IE_BIT];
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst || do_init)
		begin
			offer_q   <= 1'b0;
			ack_q     <= 1'b0;
			cmd_new_q <= 1'b0;
			count_q   <= '0;
		end
		else
		begin
			offer_q   <= wr_data || (offer_q && !(do_xfer && !done_q));
			ack_q     <= (do_xfer && !done_q) || (ack_q && !clr_ack);
			cmd_new_q <= (do_load && !ext_mode_q) || cmd_hi || (cmd_new_q && !clr_ack);
			if (do_load)
				count_q <= '0;
			else if (do_xfer && !done_q && count_q != sec_cap)
				count_q <= count_q + 9'h001;
		end
	end

	// ****************************************
	// error code, status word, config
	// ****************************************
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			err_q      <= ERR_NONE;
			status_q   <= '0;
			ext_mode_q <= 1'b0;
			devcode_q  <= DEVCODE_RST;
		end
		else
		begin
			if (wr_err)
				err_q <= reg_wdata;
			else if (do_load)
				err_q <= ERR_NONE;
			if (wr_err && reg_wdata == ERR_DCRC)
				status_q[ST_CRC_BIT] <= 1'b1;
			else if (wr_err && reg_wdata == ERR_PARITY)
				status_q[ST_PAR_BIT] <= 1'b1;
			else if (wr_stat)
				status_q <= {4'h0, reg_wdata};
			else if (do_load)
				status_q <= '0;
			if (wr_cfg)
			begin
				devcode_q  <= reg_wdata[2:0];
				ext_mode_q <= reg_wdata[3];
			end
		end
	end

	// ****************************************
	// register read mux
	// ****************************************
	wire [7:0]   rd_mux =
		reg_addr == REG_CMD   ? {fn, drive, byte_md, dbl_den, cmd_new_q, trk_bad} :
		reg_addr == REG_DATA  ? iface_q[7:0] :
		reg_addr == REG_FLAGS ? {ack_q, offer_q, ie_q, irq, err_flag_q, done_q, treq_q,
		                         state_q == ST_CMD_HI} :
		reg_addr == REG_ERR   ? err_q :
		reg_addr == REG_STAT  ? status_q[7:0] :
		reg_addr == REG_CFG   ? {4'h0, ext_mode_q, devcode_q} :
		reg_addr == REG_COUNT ? pad_cnt[8:1] : 8'h00;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ans        <= '0;
			irq        <= 1'b0;
			irq_vector <= IRQ_VECTOR;
			reg_rdata  <= 8'h00;
			init_req   <= 1'b0;
		end
		else
		begin
			ans        <= ans_d;
			irq        <= ie_q && done_q;
			irq_vector <= IRQ_VECTOR;
			reg_rdata  <= reg_rd ? rd_mux : 8'h00;
			init_req   <= do_init;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	AST_IRQ: assert property (@(posedge clock) disable iff (rst)
		ie_q && done_q |=> irq)
		else $error("irq missing with enable and done");
	AST_NOIRQ: assert property (@(posedge clock) disable iff (rst)
		!ie_q |=> !irq)
		else $error("irq without enable");
	AST_ERRDONE: assert property (@(posedge clock) disable iff (rst)
		set_err && !do_init |=> done_q && err_flag_q)
		else $error("error without done");
	AST_LOAD: assert property (@(posedge clock) disable iff (rst)
		do_load && !bus_init |=> ans.acc_clear && iface_q == $past(iot.acc))
		else $error("load did not capture and clear");
	AST_SKTR: assert property (@(posedge clock) disable iff (rst)
		do_sktr && !set_treq && !wr_data && !(do_load && ext_mode_q) && !do_init
		|=> ans.skip == $past(treq_q) && !treq_q)
		else $error("transfer request skip wrong");
	AST_OR8: assert property (@(posedge clock) disable iff (rst)
		do_xfer && byte_md && (done_q || to_host) |=> ans.acc_or && !ans.acc_jam
		&& ans.acc_data[11:8] == 4'h0)
		else $error("8-bit transfer not ORed");
	AST_NOACC: assert property (@(posedge clock) disable iff (rst)
		host_wr |=> !ans.acc_jam && !ans.acc_or && !ans.acc_clear)
		else $error("accumulator touched on write");
	AST_IENB: assert property (@(posedge clock) disable iff (rst)
		do_ien && !do_init |=> ie_q == $past(iot.acc[ACC_IE_BIT]))
		else $error("interrupt enable not updated");
	AST_DEVSEL: assert property (@(posedge clock) disable iff (rst)
		iot.valid && iot.instr[8:6] != devcode_q && !bus_init |=> ans == '0)
		else $error("answered foreign device code");
	AST_CRC: assert property (@(posedge clock) disable iff (rst)
		wr_err && reg_wdata == ERR_DCRC |=> status_q[ST_CRC_BIT] && err_q == ERR_DCRC)
		else $error("crc code without status bit");
	AST_PAR: assert property (@(posedge clock) disable iff (rst)
		wr_err && reg_wdata == ERR_PARITY |=> status_q[ST_PAR_BIT] && err_q == ERR_PARITY)
		else $error("parity code without status bit");
	AST_ERRCODE: assert property (@(posedge clock) disable iff (rst)
		wr_err |=> err_q == $past(reg_wdata))
		else $error("error code not held");
	AST_ERRCLR: assert property (@(posedge clock) disable iff (rst)
		do_load && !wr_err |=> err_q == ERR_NONE)
		else $error("error code not cleared by load");
	AST_SKER: assert property (@(posedge clock) disable iff (rst)
		do_sker && !set_err && !do_init |=> ans.skip == $past(err_flag_q) && !err_flag_q)
		else $error("error skip wrong");
	AST_SKDN: assert property (@(posedge clock) disable iff (rst)
		do_skdn && !set_done && !do_init |=> ans.skip == $past(done_q) && !done_q)
		else $error("done skip wrong");
	AST_NOP: assert property (@(posedge clock) disable iff (rst)
		sel && op == OP_NOP |=> ans == '0)
		else $error("no-op answered");
	AST_INIT: assert property (@(posedge clock) disable iff (rst)
		do_init |=> !ie_q && !done_q && !err_flag_q && !treq_q && init_req)
		else $error("initialize left flags set");
	AST_JAM12: assert property (@(posedge clock) disable iff (rst)
		do_xfer && !byte_md && (done_q || to_host) |=> ans.acc_jam && !ans.acc_or)
		else $error("12-bit transfer not jammed");
	AST_XSTAT: assert property (@(posedge clock) disable iff (rst)
		do_xfer && done_q
		|=> ans.acc_data == ($past(status_q) & ($past(byte_md) ? BYTE_MASK : 12'hfff)))
		else $error("status word not delivered");
	AST_HOSTWR: assert property (@(posedge clock) disable iff (rst)
		host_wr && !cmd_hi
		|=> iface_q == ($past(iot.acc) & ($past(byte_md) ? BYTE_MASK : 12'hfff)))
		else $error("host word not stored");
	AST_SECCAP: assert property (@(posedge clock) disable iff (rst)
		count_q <= sec_cap)
		else $error("word count beyond sector");
	AST_DDEN12: assert property (@(posedge clock) disable iff (rst)
		dbl_den && !byte_md |-> sec_cap == {SEC_WORDS12[7:0], 1'b0})
		else $error("double density 12-bit capacity wrong");
	AST_DDEN8: assert property (@(posedge clock) disable iff (rst)
		dbl_den && byte_md |-> sec_cap == {SEC_BYTES[7:0], 1'b0})
		else $error("double density 8-bit capacity wrong");
	AST_ACK: assert property (@(posedge clock) disable iff (rst)
		do_xfer && !done_q && !do_init |=> ack_q)
		else $error("transfer not acknowledged");
	AST_CMDHI: assert property (@(posedge clock) disable iff (rst)
		cmd_hi && !do_init |=> cmd_q[11:8] == $past(iot.acc[7:4]) && state_q == ST_RUN)
		else $error("upper command bits not taken");
	AST_EXTLD: assert property (@(posedge clock) disable iff (rst)
		do_load && ext_mode_q && iot.acc[CMD_WL_BIT] && state_q == ST_IDLE && !do_init
		|=> state_q == ST_CMD_HI && treq_q)
		else $error("extended load did not request upper bits");
	AST_IRQOFF: assert property (@(posedge clock) disable iff (rst)
		!done_q |=> !irq)
		else $error("irq without done");
	AST_VEC: assert property (@(posedge clock) disable iff (rst)
		irq_vector == IRQ_VECTOR)
		else $error("vector wrong");

endmodule : fhi_host_port

// File: bench/fhi_host_model.sv
// Purpose: host processor model issuing instruction words to the port
// Assumes: answers are registered on the edge that takes the instruction and are read just after it
// Notes:   keeps its own accumulator, updated from the answers and preset by wide_cmd or the bench
`timescale 1ns/1ps
module fhi_host_model
	import fhi_pkg::*;
(
	// clock
	input  wire logic     clock,
	// instruction bus
	output fhi_iot_s      iot,
	output logic          bus_init,
	input  wire fhi_ans_s ans
);
	localparam int SEC_STEP = 2;
	logic [11:0] acc_q;
	logic        skip_q;
	logic        poll_ok;
	initial
	begin
		iot      = '0;
		bus_init = 1'b0;
		acc_q    = '0;
		skip_q   = 1'b0;
		poll_ok  = 1'b0;
	end
	// one instruction, then take the answer
	task automatic exec(input logic [2:0] op, input logic [2:0] dev, input logic [2:0] mid);
		@(posedge clock);
		iot <= '{1'b1, {IOT_GROUP, dev, mid, op}, acc_q};
		@(posedge clock);
		iot.valid <= 1'b0;
		#1;
		skip_q = ans.skip;
		if (ans.acc_clear)
			acc_q = '0;
		if (ans.acc_jam)
			acc_q = ans.acc_data;
		if (ans.acc_or)
			acc_q = acc_q | ans.acc_data;
	endtask : exec
	// byte mode command: low part, wait for request, upper part
	task automatic wide_cmd(input logic [2:0] dev, input logic [11:0] cmd);
		acc_q = {4'h0, cmd[7:0]};
		exec(OP_LOAD, dev, 3'h0);
		skip_q = 1'b0;
		for (int i = 0; i < 8 && !skip_q; i++)
			exec(OP_SKTR, dev, 3'h0);
		poll_ok = skip_q;
		acc_q = {4'h0, cmd[11:8], 4'h0};
		exec(OP_XFER, dev, 3'h0);
	endtask : wide_cmd
	task automatic pulse_init;
		@(posedge clock);
		bus_init <= 1'b1;
		@(posedge clock);
		bus_init <= 1'b0;
	endtask : pulse_init
	// sector numbers the host walks with a two-sector interleave
	function automatic logic [11:0] sector_no(input int k);
		sector_no = 12'(1 + SEC_STEP * k);
	endfunction : sector_no
endmodule : fhi_host_model

// File: bench/fhi_host_port_tb.sv
// Purpose: self-checking bench for the floppy host instruction port
// Assumes: host model issues instructions, bench drives the register port
// Notes:   expectations come from the octal codes and the field layout
`timescale 1ns/1ps
module fhi_host_port_tb
	import fhi_pkg::*;
;
	localparam logic [2:0] DEV = 3'h5;
	// error code beside expected status byte
	localparam logic [15:0] ERR_ROWS [24] = '{
		16'h0000, 16'h0800, 16'h1000, 16'h1800, 16'h2000, 16'h2800, 16'h3800, 16'h4000,
		16'h4800, 16'h5000, 16'h5800, 16'h6000, 16'h6800, 16'h7000, 16'h7800, 16'h8001,
		16'h8802, 16'h9800, 16'ha000, 16'ha800, 16'hb000, 16'he800, 16'hf000, 16'hf800};
	// command word beside command readback and pad count
	localparam logic [27:0] CMD_ROWS [5] = '{
		28'h3a07a40, 28'h0800220, 28'h1c02640, 28'h0600e80, 28'h4a09a40};
	logic               clock;
	logic               rst;
	fhi_iot_s           iot;
	logic               bus_init;
	fhi_ans_s           ans;
	logic               irq;
	logic [8:0]         irq_vector;
	logic [RADDR_W-1:0] reg_addr;
	logic [7:0]         reg_wdata;
	logic               reg_wr;
	logic               reg_rd;
	logic [7:0]         reg_rdata;
	logic               init_req;
	logic [7:0]         rd_v;
	int                 err_total;
	int                 comparisons;
	fhi_host_port DUT (.clock, .rst, .iot, .bus_init, .ans, .irq, .irq_vector,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .init_req);
	fhi_host_model host (.clock, .iot, .bus_init, .ans);
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_bit(input logic got, input logic exp);
		chk({11'h0, got}, {11'h0, exp});
	endtask : chk_bit
	task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [2:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		rd_v = reg_rdata;
	endtask : reg_read
	task automatic op(input logic [2:0] o);
		host.exec(o, DEV, 3'h2);
	endtask : op
	task automatic settle;
		repeat (2) @(posedge clock);
		#1;
	endtask : settle
	task automatic tally_and_finish;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial
	begin
		repeat (20000) @(posedge clock);
		err_total++;
		tally_and_finish();
	end
	// ****************************************
	// sequence
	// ****************************************
	initial
	begin
		err_total   = 0;
		comparisons = 0;
		rst         = 1'b1;
		reg_addr    = '0;
		reg_wdata   = '0;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		rd_v        = '0;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		#1;
		chk({3'h0, irq_vector}, 12'h0b4);
		chk_bit(irq, 1'b0);
		reg_write(REG_CFG, {5'h0, DEV});
		foreach (ERR_ROWS[i])
		begin
			host.acc_q = '0;
			op(OP_LOAD);
			reg_write(REG_ERR, ERR_ROWS[i][15:8]);
			reg_read(REG_ERR);
			chk({4'h0, rd_v}, {4'h0, ERR_ROWS[i][15:8]});
			reg_read(REG_STAT);
			chk({4'h0, rd_v}, {4'h0, ERR_ROWS[i][7:0]});
			host.exec(OP_SKER, DEV, i[2:0]);
			chk_bit(host.skip_q, |ERR_ROWS[i]);
			host.exec(OP_SKDN, DEV, i[2:0]);
			chk_bit(host.skip_q, |ERR_ROWS[i]);
		end
		foreach (CMD_ROWS[i])
		begin
			host.acc_q = CMD_ROWS[i][27:16];
			op(OP_LOAD);
			chk(host.acc_q, 12'h000);
			reg_read(REG_CMD);
			chk({4'h0, rd_v & 8'hfe}, {4'h0, CMD_ROWS[i][15:8]});
			reg_read(REG_COUNT);
			chk({4'h0, rd_v}, {4'h0, CMD_ROWS[i][7:0]});
		end
		reg_write(REG_FLAGS, 8'h01);
		host.exec(OP_SKTR, 3'h2, 3'h0);
		chk_bit(host.skip_q, 1'b0);
		op(OP_NOP);
		chk_bit(host.skip_q, 1'b0);
		op(OP_SKTR);
		chk_bit(host.skip_q, 1'b1);
		op(OP_SKTR);
		chk_bit(host.skip_q, 1'b0);
		host.acc_q = 12'h100;
		op(OP_LOAD);
		reg_write(REG_DATA, 8'h5a);
		host.acc_q = 12'hfff;
		op(OP_XFER);
		chk(host.acc_q, 12'h05a);
		reg_read(REG_FLAGS);
		chk_bit(rd_v[7], 1'b1);
		host.acc_q = 12'h120;
		op(OP_LOAD);
		reg_write(REG_DATA, 8'h0f);
		host.acc_q = 12'hf00;
		op(OP_XFER);
		chk(host.acc_q, 12'hf0f);
		host.acc_q = 12'h000;
		op(OP_LOAD);
		host.acc_q = 12'h123;
		op(OP_XFER);
		chk(host.acc_q, 12'h123);
		reg_read(REG_DATA);
		chk({4'h0, rd_v}, 12'h023);
		for (int k = 0; k < 2; k++)
		begin
			host.acc_q = host.sector_no(k);
			op(OP_XFER);
			reg_read(REG_DATA);
			chk({4'h0, rd_v}, {k[10:0], 1'b1});
		end
		host.acc_q = 12'h04d;
		op(OP_XFER);
		reg_read(REG_CMD);
		chk_bit(rd_v[0], 1'b1);
		host.acc_q = 12'h04c;
		op(OP_XFER);
		reg_read(REG_CMD);
		chk_bit(rd_v[0], 1'b0);
		reg_write(REG_STAT, 8'h04);
		reg_write(REG_FLAGS, 8'h02);
		op(OP_XFER);
		chk(host.acc_q, 12'h004);
		op(OP_SKDN);
		reg_write(REG_CFG, {4'h0, 1'b1, DEV});
		host.wide_cmd(DEV, 12'h320);
		chk_bit(host.poll_ok, 1'b1);
		reg_read(REG_CMD);
		chk({4'h0, rd_v & 8'hfe}, 12'h06a);
		reg_write(REG_CFG, {5'h0, DEV});
		reg_read(3'h7);
		chk({4'h0, rd_v}, 12'h000);
		host.acc_q = 12'h001 << ACC_IE_BIT;
		op(OP_IEN);
		reg_write(REG_FLAGS, 8'h02);
		settle();
		chk_bit(irq, 1'b1);
		host.acc_q = '0;
		op(OP_IEN);
		settle();
		chk_bit(irq, 1'b0);
		host.acc_q = 12'h001 << ACC_IE_BIT;
		op(OP_IEN);
		settle();
		chk_bit(irq, 1'b1);
		op(OP_SKDN);
		chk_bit(host.skip_q, 1'b1);
		settle();
		chk_bit(irq, 1'b0);
		host.pulse_init();
		reg_write(REG_FLAGS, 8'h02);
		settle();
		chk_bit(irq, 1'b0);
		reg_write(REG_CFG, {5'h0, DEV});
		host.acc_q = 12'h001 << ACC_IE_BIT;
		op(OP_IEN);
		op(OP_INIT);
		chk_bit(init_req, 1'b1);
		reg_write(REG_FLAGS, 8'h02);
		settle();
		chk_bit(irq, 1'b0);
		reg_write(REG_CFG, {5'h0, DEV});
		op(OP_IEN);
		reg_write(REG_FLAGS, 8'h02);
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		settle();
		chk_bit(irq, 1'b0);
		reg_read(REG_FLAGS);
		chk({4'h0, rd_v}, 12'h000);
		tally_and_finish();
	end
endmodule : fhi_host_port_tb
